// ===== rtl/dau_defines.vh
// Constants for the converter update and digital port block.
// Assumes a 32-bit Avalon-MM slave with byte addresses.
`ifndef DAU_DEFINES_VH
`define DAU_DEFINES_VH

// ----------------------------------------
// Widths
// ----------------------------------------
`define DAU_AW        5
`define DAU_DW        32
`define DAU_CODE_W    12
`define DAU_CODE_MSB  11
`define DAU_DIO_W     8

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define DAU_OFF_CODE0 5'h00
`define DAU_OFF_CODE1 5'h04
`define DAU_OFF_CTRL  5'h08
`define DAU_OFF_DOUT  5'h0C
`define DAU_OFF_DIN   5'h10
`define DAU_OFF_STAT  5'h14

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define DAU_CTL_TMR   0
`define DAU_CTL_TRG   1
`define DAU_CTL_PA    2
`define DAU_CTL_PB    3
`define DAU_CTL_W     4

// ----------------------------------------
// Status register fields
// ----------------------------------------
`define DAU_ST_PEND0  0
`define DAU_ST_PEND1  1
`define DAU_ST_UNI    2
`define DAU_ST_TWOS   3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define DAU_RST_CODE  12'h000
`define DAU_RST_CTRL  4'h0
`define DAU_RST_DIO   8'h00
`define DAU_RST_UNI   1'b0
`define DAU_RST_TWOS  1'b1

`endif

// ===== rtl/dau_top.v
// Converter update control and eight-line digital port.
// Assumes an Avalon-MM master on core_clk and pin inputs that are
// already synchronous to core_clk.
//
// Functional notes
// RQ1 - Hold one 12-bit code per channel
// RQ2 - Channel zero write touches channel zero only
// RQ3 - Channel one write touches channel one only
// RQ4 - Three update moments chosen by two bits
// RQ5 - Trigger bus mode applies on low pulse
// RQ6 - Timer mode applies on counter-two low pulse
// RQ7 - Neither bit set: apply on write
// RQ8 - Unipolar code is straight binary 0..4095
// RQ9 - Bipolar binary: 0800 is zero output
// RQ10 - Two's complement: F800..07FF signed codes
// RQ11 - Coding fixed by straps, default bipolar twos
// RQ12 - Port A driven from output bits when enabled
// RQ13 - Port B driven from output bits when enabled
// RQ14 - One write updates both port patterns
// RQ15 - Outside drives lines only while disabled
// RQ16 - Input register reads all eight lines
// RQ17 - Enabled ports read back own drive
// RQ18 - Bits 3..0 port A, 7..4 port B
// RQ19 - Code taken from write bits 11..0
`timescale 1ns/1ps
`include "dau_defines.vh"

module dau_top (
  input  wire                   core_clk,
  input  wire                   rstn,
  input  wire [`DAU_AW-1:0]     avs_address,
  input  wire                   avs_read,
  input  wire                   avs_write,
  input  wire [`DAU_DW-1:0]     avs_writedata,
  output reg  [`DAU_DW-1:0]     avs_readdata,
  output reg                    avs_waitrequest,
  input  wire                   counter_two_output,
  input  wire                   system_trigger_bus,
  input  wire                   unipolar_strap,
  input  wire                   twos_comp_strap,
  output reg  [`DAU_CODE_W-1:0] analog_out_ch0_pin,
  output reg  [`DAU_CODE_W-1:0] analog_out_ch1_pin,
  input  wire [`DAU_DIO_W-1:0]  dio_in,
  output reg  [`DAU_DIO_W-1:0]  dio_out,
  output reg  [`DAU_DIO_W-1:0]  dio_oe
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------

  // Address match used by both bus paths
  function hit;
    input [`DAU_AW-1:0] a;
    input [`DAU_AW-1:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  // Map a held code onto the converter input word
  function [`DAU_CODE_W-1:0] to_dac;
    input [`DAU_CODE_W-1:0] c;
    input                   twos;
    begin
      // Signed codes flip the sign to offset binary
      if (twos) begin
        to_dac = {~c[`DAU_CODE_MSB], c[`DAU_CODE_MSB-1:0]};
      end else begin
        to_dac = c;
      end
    end
  endfunction

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  reg [`DAU_CODE_W-1:0] code0_r;      // Held channel zero code
  reg [`DAU_CODE_W-1:0] code1_r;      // Held channel one code
  reg [`DAU_CTL_W-1:0]  ctrl_r;       // Update and drive enables
  reg [`DAU_DIO_W-1:0]  dout_r;       // Digital output pattern
  reg [`DAU_DIO_W-1:0]  din_r;        // Sampled line levels
  reg                   pend0_r;      // Channel zero awaits update
  reg                   pend1_r;      // Channel one awaits update
  reg                   uni_r;        // Unipolar configuration
  reg                   twos_r;       // Two's complement coding
  reg                   strap_done_r; // Straps already caught
  reg                   tmr_prev_r;   // Last counter-two level
  reg                   trg_prev_r;   // Last trigger bus level
  reg                   pend0_nxt;    // Next pending flags
  reg                   pend1_nxt;
  reg [`DAU_DW-1:0]     rdata_nxt;    // Read mux result

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------

  // Access completes on the edge where waitrequest is low
  wire acc_go  = (avs_read | avs_write) & ~avs_waitrequest;
  wire wr_go   = avs_write & ~avs_waitrequest;
  wire wr_c0   = wr_go & hit(avs_address, `DAU_OFF_CODE0);
  wire wr_c1   = wr_go & hit(avs_address, `DAU_OFF_CODE1);
  wire wr_ctl  = wr_go & hit(avs_address, `DAU_OFF_CTRL);
  wire wr_dout = wr_go & hit(avs_address, `DAU_OFF_DOUT);

  // Update mode selection, trigger bus takes priority
  wire mode_trg = ctrl_r[`DAU_CTL_TRG];
  wire mode_tmr = ctrl_r[`DAU_CTL_TMR] & ~mode_trg;
  wire mode_imm = ~ctrl_r[`DAU_CTL_TRG] & ~ctrl_r[`DAU_CTL_TMR];

  // Falling edges mark the start of an active-low pulse
  wire tmr_fall = tmr_prev_r & ~counter_two_output;
  wire trg_fall = trg_prev_r & ~system_trigger_bus;
  wire upd_ev   = (mode_trg & trg_fall) | (mode_tmr & tmr_fall); // RQ5 RQ6

  // Held code shown as a sign-extended word in signed coding
  wire [`DAU_DW-1:0] code0_rd = (twos_r & ~uni_r) ?
    {{(`DAU_DW-`DAU_CODE_W){code0_r[`DAU_CODE_MSB]}}, code0_r} :
    {{(`DAU_DW-`DAU_CODE_W){1'b0}}, code0_r};
  wire [`DAU_DW-1:0] code1_rd = (twos_r & ~uni_r) ?
    {{(`DAU_DW-`DAU_CODE_W){code1_r[`DAU_CODE_MSB]}}, code1_r} :
    {{(`DAU_DW-`DAU_CODE_W){1'b0}}, code1_r};

  // ----------------------------------------
  // Bus handshake
  // ----------------------------------------

  // Waitrequest drops one cycle after a request, rises after it
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= {`DAU_DW{1'b0}};
    end else if (acc_go) begin
      // Access taken now, next request waits again
      avs_waitrequest <= 1'b1;
    end else if (avs_read | avs_write) begin
      // Answer ready at the following edge
      avs_waitrequest <= 1'b0;
      avs_readdata    <= rdata_nxt;
    end
  end

  // Read mux, unmapped addresses read zero
  always @* begin
    rdata_nxt = {`DAU_DW{1'b0}};
    if (hit(avs_address, `DAU_OFF_CODE0)) begin
      rdata_nxt = code0_rd;
    end else if (hit(avs_address, `DAU_OFF_CODE1)) begin
      rdata_nxt = code1_rd;
    end else if (hit(avs_address, `DAU_OFF_CTRL)) begin
      rdata_nxt[`DAU_CTL_W-1:0] = ctrl_r;
    end else if (hit(avs_address, `DAU_OFF_DOUT)) begin
      rdata_nxt[`DAU_DIO_W-1:0] = dout_r;
    end else if (hit(avs_address, `DAU_OFF_DIN)) begin
      rdata_nxt[`DAU_DIO_W-1:0] = din_r; // RQ16 RQ17
    end else if (hit(avs_address, `DAU_OFF_STAT)) begin
      rdata_nxt[`DAU_ST_PEND0] = pend0_r;
      rdata_nxt[`DAU_ST_PEND1] = pend1_r;
      rdata_nxt[`DAU_ST_UNI]   = uni_r;
      rdata_nxt[`DAU_ST_TWOS]  = twos_r;
    end
  end

  // ----------------------------------------
  // Configuration straps
  // ----------------------------------------

  // Straps caught once on the first edge after reset release
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      uni_r        <= `DAU_RST_UNI;  // RQ11
      twos_r       <= `DAU_RST_TWOS; // RQ11
      strap_done_r <= 1'b0;
    end else if (!strap_done_r) begin
      uni_r        <= unipolar_strap;  // RQ11
      twos_r       <= twos_comp_strap; // RQ11
      strap_done_r <= 1'b1;
    end
  end

  // ----------------------------------------
  // Control and held codes
  // ----------------------------------------

  // Registers written by software
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      code0_r <= `DAU_RST_CODE;
      code1_r <= `DAU_RST_CODE;
      ctrl_r  <= `DAU_RST_CTRL;
      dout_r  <= `DAU_RST_DIO;
    end else begin
      // Low twelve bits form the code
      if (wr_c0) begin
        code0_r <= avs_writedata[`DAU_CODE_MSB:0]; // RQ1 RQ19
      end
      if (wr_c1) begin
        code1_r <= avs_writedata[`DAU_CODE_MSB:0]; // RQ1 RQ19
      end
      // Two update bits and two drive enables
      if (wr_ctl) begin
        ctrl_r <= avs_writedata[`DAU_CTL_W-1:0]; // RQ4
      end
      // Both port patterns from one write
      if (wr_dout) begin
        dout_r <= avs_writedata[`DAU_DIO_W-1:0]; // RQ14
      end
    end
  end

  // ----------------------------------------
  // Update pulses
  // ----------------------------------------

  // Previous levels for pulse edge detection, idle high
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      tmr_prev_r <= 1'b1;
      trg_prev_r <= 1'b1;
    end else begin
      tmr_prev_r <= counter_two_output;
      trg_prev_r <= system_trigger_bus;
    end
  end

  // Pending flags, a write in the pulse cycle stays pending
  always @* begin
    pend0_nxt = pend0_r;
    pend1_nxt = pend1_r;
    if (upd_ev) begin
      pend0_nxt = 1'b0;
      pend1_nxt = 1'b0;
    end
    if (mode_imm) begin
      // Immediate mode never leaves a code waiting
      pend0_nxt = 1'b0;
      pend1_nxt = 1'b0;
    end else begin
      // Set wins over the clear
      if (wr_c0) begin
        pend0_nxt = 1'b1;
      end
      if (wr_c1) begin
        pend1_nxt = 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Converter outputs
  // ----------------------------------------

  // Converter words follow held codes at the chosen moment
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      analog_out_ch0_pin <= `DAU_RST_CODE;
      analog_out_ch1_pin <= `DAU_RST_CODE;
      pend0_r            <= 1'b0;
      pend1_r            <= 1'b0;
    end else begin
      pend0_r <= pend0_nxt;
      pend1_r <= pend1_nxt;
      if (mode_imm) begin
        // Direct pass on the write itself
        if (wr_c0) begin
          analog_out_ch0_pin <= to_dac(avs_writedata[`DAU_CODE_MSB:0],
                                       twos_r & ~uni_r); // RQ7 RQ2
        end
        if (wr_c1) begin
          analog_out_ch1_pin <= to_dac(avs_writedata[`DAU_CODE_MSB:0],
                                       twos_r & ~uni_r); // RQ7 RQ3
        end
      end else if (upd_ev) begin
        // Pulse applies codes held before this edge
        if (pend0_r) begin
          analog_out_ch0_pin <= to_dac(code0_r, twos_r & ~uni_r); // RQ8 RQ9 RQ10
        end
        if (pend1_r) begin
          analog_out_ch1_pin <= to_dac(code1_r, twos_r & ~uni_r); // RQ8 RQ9 RQ10
        end
      end
    end
  end

  // ----------------------------------------
  // Digital lines
  // ----------------------------------------

  // Line levels sampled every cycle, whoever drives them
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      din_r <= `DAU_RST_DIO;
    end else begin
      din_r <= dio_in; // RQ16
    end
  end

  // Per-line enable, low nibble port A, high nibble port B
  wire [`DAU_DIO_W-1:0] line_en; // Enable wanted for each line
  genvar gi;
  generate
    for (gi = 0; gi < `DAU_DIO_W; gi = gi + 1) begin : g_line
      // Port select from line position
      assign line_en[gi] = (gi < (`DAU_DIO_W / 2)) ? ctrl_r[`DAU_CTL_PA] :
                                                     ctrl_r[`DAU_CTL_PB]; // RQ18
    end
  endgenerate

  // One register stage for all lines, a released line is left to outside
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      dio_out <= `DAU_RST_DIO;
      dio_oe  <= `DAU_RST_DIO;
    end else begin
      dio_out <= dout_r;  // RQ12 RQ13
      dio_oe  <= line_en; // RQ12 RQ13
    end
  end

endmodule

// ===== dv/dau_top_sva.sv
// Checker for the converter update and digital port block.
// Assumes the register map of dau_defines.vh and one clock domain.
`timescale 1ns/1ps
`include "dau_defines.vh"
module dau_chk (
  input wire                   core_clk,
  input wire                   rstn,
  input wire [`DAU_AW-1:0]     avs_address,
  input wire                   avs_read,
  input wire                   avs_write,
  input wire [`DAU_DW-1:0]     avs_writedata,
  input wire                   avs_waitrequest,
  input wire                   system_trigger_bus,
  input wire                   unipolar_strap,
  input wire                   twos_comp_strap,
  input wire [`DAU_CODE_W-1:0] analog_out_ch0_pin,
  input wire [`DAU_CODE_W-1:0] analog_out_ch1_pin,
  input wire [`DAU_DIO_W-1:0]  dio_out,
  input wire [`DAU_DIO_W-1:0]  dio_oe
);
  // ----------------------------------------
  // Helper logic: shadow of control bits
  // ----------------------------------------
  logic [3:0]  ctrl_r;  // Control bits as written
  logic [31:0] wd_r;    // Write data of the last cycle
  logic        trg_r;   // Trigger line one edge ago
  wire         tk_wr = avs_write && !avs_waitrequest;
  wire [11:0]  flip = (!unipolar_strap && twos_comp_strap) ? 12'h800 : 12'h000;
  wire         trg_fall = trg_r && !system_trigger_bus;
  // Track control writes and line history
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_r <= 4'h0;
      trg_r  <= 1'b1;
    end else begin
      trg_r <= system_trigger_bus;
      if (tk_wr && avs_address == `DAU_OFF_CTRL) begin
        ctrl_r <= avs_writedata[3:0];
      end
    end
  end
  // Capture write data every cycle
  always @(posedge core_clk) begin
    wd_r <= avs_writedata;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  AST_WAIT_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  AST_WAIT_ANSWER: assert property ((avs_read || avs_write) && avs_waitrequest |=>
    !avs_waitrequest) else $error("access not answered in one cycle");
  AST_IMM_CH0: assert property (tk_wr && avs_address == `DAU_OFF_CODE0 && ctrl_r[1:0] == 2'b00
    |=> analog_out_ch0_pin == (wd_r[11:0] ^ flip)) else $error("ch0 not updated on write");
  AST_CH1_KEEP: assert property (tk_wr && avs_address == `DAU_OFF_CODE0 && ctrl_r[1:0] == 2'b00
    |=> $stable(analog_out_ch1_pin)) else $error("ch1 moved on ch0 write");
  AST_CH0_KEEP: assert property (tk_wr && avs_address == `DAU_OFF_CODE1 && ctrl_r[1:0] == 2'b00
    |=> $stable(analog_out_ch0_pin)) else $error("ch0 moved on ch1 write");
  AST_TRG_HOLD: assert property (ctrl_r[1] && !trg_fall |=> $stable(analog_out_ch0_pin))
    else $error("ch0 moved without trigger pulse");
  AST_DIO_OUT: assert property (tk_wr && avs_address == `DAU_OFF_DOUT |=> ##1
    dio_out == $past(avs_writedata[7:0], 2)) else $error("drive pattern not updated");
  AST_OE: assert property (dio_oe == {{4{$past(ctrl_r[3])}}, {4{$past(ctrl_r[2])}}})
    else $error("drive enables differ from control bits");
endmodule
bind dau_top dau_chk u_dau_chk (.core_clk, .rstn, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_waitrequest, .system_trigger_bus, .unipolar_strap, .twos_comp_strap,
  .analog_out_ch0_pin, .analog_out_ch1_pin, .dio_out, .dio_oe);

// ===== dv/dau_top_tb.sv
// Self-checking bench for the converter update and digital port block.
// Assumes dau_top with an Avalon-MM slave; the bench resolves the lines.
`timescale 1ns/1ps
`include "dau_defines.vh"
module dau_top_tb;
  logic        core_clk, rstn, avs_read, avs_write, avs_waitrequest;
  logic        counter_two_output, system_trigger_bus, unipolar_strap, twos_comp_strap;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [11:0] analog_out_ch0_pin, analog_out_ch1_pin, c0, c1, e0, e1;
  logic [7:0]  dio_in, dio_out, dio_oe, ext_r, d, oe_x;
  logic [15:0] rnd_r;  // Random source state
  int          n_fail, n_checks;
  // Resolved lines: own drive where enabled, outside device elsewhere
  assign dio_in = (dio_oe & dio_out) | (~dio_oe & ext_r);
  dau_top u_dau_top (.core_clk, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .counter_two_output, .system_trigger_bus, .unipolar_strap,
    .twos_comp_strap, .analog_out_ch0_pin, .analog_out_ch1_pin, .dio_in, .dio_out, .dio_oe);
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Converter word expected for a code under the present straps
  function automatic logic [11:0] exp_word(input logic [11:0] c);
    return (!unipolar_strap && twos_comp_strap) ? c ^ 12'h800 : c;
  endfunction
  // Code register read value: sign-extended only in two's complement
  function automatic logic [31:0] exp_rd(input logic [11:0] c);
    return (!unipolar_strap && twos_comp_strap) ? {{20{c[11]}}, c} : {20'h0, c};
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_out(input logic [11:0] x0, input logic [11:0] x1);
    @(negedge core_clk);
    chk("ch0", {20'h0, x0}, {20'h0, analog_out_ch0_pin});
    chk("ch1", {20'h0, x1}, {20'h0, analog_out_ch1_pin});
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] v);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= v;
    avs_write <= 1'b1;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0) @(posedge core_clk);
    avs_write <= 1'b0;
  endtask
  task automatic rdr(input logic [4:0] a, output logic [31:0] v);
    @(posedge core_clk);
    avs_address <= a;
    avs_read <= 1'b1;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0) @(posedge core_clk);
    v = avs_readdata;
    avs_read <= 1'b0;
  endtask
  // One low cycle on the trigger bus (sel) or the counter output
  task automatic pulse(input logic sel);
    @(posedge core_clk);
    if (sel) system_trigger_bus <= 1'b0;
    else counter_two_output <= 1'b0;
    @(posedge core_clk);
    system_trigger_bus <= 1'b1;
    counter_two_output <= 1'b1;
    repeat (2) @(posedge core_clk);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    report_and_stop;
  end
  initial begin
    rstn = 1'b0; avs_read = 1'b0; avs_write = 1'b0; avs_address = 5'h00;
    avs_writedata = 32'h0; counter_two_output = 1'b1; system_trigger_bus = 1'b1;
    unipolar_strap = 1'b0; twos_comp_strap = 1'b1; ext_r = 8'h00; rnd_r = 16'h0001;
    // Strap sets: bipolar two's complement, unipolar, bipolar binary
    for (int cfg = 0; cfg < 3; cfg++) begin
      rstn <= 1'b0;
      unipolar_strap <= (cfg == 1);
      twos_comp_strap <= (cfg == 0);
      repeat (10) @(posedge core_clk);
      rstn <= 1'b1;
      chk_out(12'h000, 12'h000);
      rdr(`DAU_OFF_STAT, rd);
      chk("stat", {28'h0, twos_comp_strap, unipolar_strap, 2'b00}, rd);
      wr(`DAU_OFF_CODE0, 32'h0000F800);
      chk_out(exp_word(12'h800), 12'h000);
      wr(`DAU_OFF_CODE1, 32'h000007FF);
      e0 = exp_word(12'h800);
      e1 = exp_word(12'h7FF);
      chk_out(e0, e1);
      rdr(`DAU_OFF_CODE0, rd);
      chk("code0", exp_rd(12'h800), rd);
      // Held modes: 1 timer, 2 trigger bus; wrong source is ignored
      for (int m = 1; m < 3; m++) begin
        wr(`DAU_OFF_CTRL, m);
        rnd_r = lfsr(rnd_r);
        c0 = rnd_r[11:0];
        wr(`DAU_OFF_CODE0, {rnd_r, rnd_r});
        rnd_r = lfsr(rnd_r);
        c1 = rnd_r[11:0];
        wr(`DAU_OFF_CODE1, {rnd_r, rnd_r});
        chk_out(e0, e1);
        rdr(`DAU_OFF_STAT, rd);
        chk("stat", {28'h0, twos_comp_strap, unipolar_strap, 2'b11}, rd);
        pulse(m == 1);
        chk_out(e0, e1);
        pulse(m == 2);
        e0 = exp_word(c0);
        e1 = exp_word(c1);
        chk_out(e0, e1);
      end
      // Port enables in all four combinations
      for (int k = 0; k < 4; k++) begin
        wr(`DAU_OFF_CTRL, k << 2);
        rnd_r = lfsr(rnd_r);
        d = rnd_r[7:0];
        wr(`DAU_OFF_DOUT, {16'h0, rnd_r});
        ext_r <= rnd_r[15:8] ^ 8'hFF;
        oe_x = {{4{k[1]}}, {4{k[0]}}};
        // Drive pattern reaches the pins one edge after the write edge
        @(posedge core_clk);
        @(negedge core_clk);
        chk("oe", {24'h0, oe_x}, {24'h0, dio_oe});
        chk("dout", {24'h0, d}, {24'h0, dio_out});
        repeat (2) @(posedge core_clk);
        rdr(`DAU_OFF_DIN, rd);
        chk("din", {24'h0, (oe_x & d) | (~oe_x & ext_r)}, rd);
      end
      rdr(5'h18, rd);
      chk("unmapped", 32'h0, rd);
    end
    report_and_stop;
  end
endmodule
